// [hdl/rsirq_pkg.sv]
// Purpose: constants, state codes and helpers for the rail status and irq mask slice
// Assumes: 8-bit registers reached over the two-wire serial bus
// Notes:   every offset, field position and reset value lives here once
package rsirq_pkg;
   // register offsets
   localparam logic [7:0] OFS_FLAGS     = 8'h18;
   localparam logic [7:0] OFS_TOP_STAT  = 8'h1d;
   localparam logic [7:0] OFS_BUCK_STAT = 8'h1e;
   localparam logic [7:0] OFS_LDO_RAIL_STATUS  = 8'h1f;
   localparam logic [7:0] OFS_MASK      = 8'h20;
   // rail status field positions, same layout for both rail kinds
   localparam int RAIL1_EN_BIT  = 7;
   localparam int RAIL1_INV_BIT = 6;
   localparam int RAIL1_LIM_BIT = 4;
   localparam int RAIL0_EN_BIT  = 3;
   localparam int RAIL0_INV_BIT = 2;
   localparam int RAIL0_LIM_BIT = 0;
   // top-level event positions, shared by flags and mask, and by status for all but MEAS_BIT
   localparam int POK_BIT   = 7;
   localparam int CLK_BIT   = 4;
   localparam int THERM_BIT = 2;
   localparam int MEAS_BIT  = 0;
   // reset values
   localparam logic [7:0] MASK_RST  = 8'h90;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // bus constants
   localparam logic [6:0] DEV_ADDR_DFLT = 7'h60; // arbitrary value
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // serial engine states
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_ACK_A = 9'h004,
      ST_REG   = 9'h008,
      ST_ACK_R = 9'h010,
      ST_WDATA = 9'h020,
      ST_ACK_W = 9'h040,
      ST_RDATA = 9'h080,
      ST_RACK  = 9'h100
   } rsirq_state_e;
   // packs six raw rail bits {en1,inv1,lim1,en0,inv0,lim0} into a status byte
   function automatic logic [7:0] rsirq_pack_rail(input logic [5:0] raw);
      logic [7:0] b;
      b = BYTE_ZERO;
      b[RAIL1_EN_BIT]  = raw[5];
      b[RAIL1_INV_BIT] = raw[4];
      b[RAIL1_LIM_BIT] = raw[3];
      b[RAIL0_EN_BIT]  = raw[2];
      b[RAIL0_INV_BIT] = raw[1];
      b[RAIL0_LIM_BIT] = raw[0];
      return b;
   endfunction
endpackage

// [hdl/rsirq_regs.sv]
// Purpose: register storage, interrupt flags and read mux of the slice
// Assumes: all inputs synchronous to core_clk
// Notes:   raw status is never stored, it is read live
`timescale 1ns/100ps
`default_nettype none
module rsirq_regs
   import rsirq_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // register access
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_addr,
   input  wire logic [7:0] wr_data,
   input  wire logic [7:0] rd_addr,
   output logic      [7:0] rd_data,
   output logic            irq_req,
   // raw rail status {en1,inv1,lim1,en0,inv0,lim0}
   input  wire logic [5:0] buck_raw,
   input  wire logic [5:0] ldo_raw,
   // top-level monitors
   input  wire logic       power_ok_pin_state,
   input  wire logic       ext_clk_invalid,
   input  wire logic       thermal_warning_state,
   input  wire logic       load_meas_done
);
   logic [7:0] flags_reg, flags_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] top_stat, events, clr;
   logic       pok_prev_reg, clk_prev_reg, therm_prev_reg;

   // flag and mask next values
   always_comb begin
      top_stat            = BYTE_ZERO;
      top_stat[POK_BIT]   = power_ok_pin_state;
      top_stat[CLK_BIT]   = ext_clk_invalid;
      top_stat[THERM_BIT] = thermal_warning_state;
      events              = BYTE_ZERO;
      events[POK_BIT]     = power_ok_pin_state ^ pok_prev_reg;  // any pin change
      events[CLK_BIT]     = ext_clk_invalid & ~clk_prev_reg;
      events[THERM_BIT]   = thermal_warning_state & ~therm_prev_reg;
      events[MEAS_BIT]    = load_meas_done;
      clr = (wr_en && wr_addr == OFS_FLAGS) ? wr_data : BYTE_ZERO;
      // set beats clear so an event in the clearing cycle survives
      flags_next = (flags_reg & ~clr) | events;
      mask_next  = (wr_en && wr_addr == OFS_MASK) ? wr_data : mask_reg;
   end

   // masks reset values
   // reset constants also cover the other gates
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flags_reg      <= FLAGS_RST;
         mask_reg       <= MASK_RST;
         pok_prev_reg   <= 1'b0;
         clk_prev_reg   <= 1'b0;
         therm_prev_reg <= 1'b0;
      end else begin
         flags_reg      <= flags_next;
         mask_reg       <= mask_next;
         pok_prev_reg   <= power_ok_pin_state;
         clk_prev_reg   <= ext_clk_invalid;
         therm_prev_reg <= thermal_warning_state;
      end
   end

   // masked flag request
   // gates: one means suppressed
   assign irq_req = |(flags_reg & ~mask_reg);

   // read mux; unmapped offsets read zero
   always_comb begin
      case (rd_addr)
         OFS_FLAGS:     rd_data = flags_reg;
         OFS_TOP_STAT:  rd_data = top_stat;
         OFS_BUCK_STAT: rd_data = rsirq_pack_rail(buck_raw);
         OFS_LDO_RAIL_STATUS:  rd_data = rsirq_pack_rail(ldo_raw);
         OFS_MASK:      rd_data = mask_reg;
         default:       rd_data = BYTE_ZERO;
      endcase
   end
endmodule
`default_nettype wire

// [hdl/rsirq_top.sv]
// Purpose: two-wire serial slave in front of the rail status and irq mask registers
// Assumes: scl and sda already synchronous to core_clk, core_clk far above scl
// Notes:   pointer auto-increments after each data byte; no clock stretching
`timescale 1ns/100ps
`default_nettype none
//
// Contract
// - buck enable bits 7 and 3
// - buck voltage invalid bits 6 and 2
// - buck current limit bits 4 and 0
// - regulator enable bits 7 and 3
// - regulator voltage invalid bits 6 and 2
// - regulator current limit bits 4 and 0
// - mask bit7 gates power-good, resets one
// - power-good mask leaves its status alone
// - mask bit4 gates clock detect, resets one
// - clock mask leaves clock status alone
// - mask bit2 gates thermal warning, resets zero
// - thermal mask leaves thermal status alone
// - mask bit0 gates measurement ready, resets zero
// - flags latch until host writes one
module rsirq_top
   import rsirq_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
)(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // serial bus, sda open drain
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // buck converter raw status
   input  wire logic conv1_enabled,
   input  wire logic conv1_vout_invalid,
   input  wire logic conv1_current_limited,
   input  wire logic conv0_enabled,
   input  wire logic conv0_vout_invalid,
   input  wire logic conv0_current_limited,
   // linear regulator raw status
   input  wire logic linreg1_enabled,
   input  wire logic linreg1_vout_invalid,
   input  wire logic linreg1_current_limited,
   input  wire logic linreg0_enabled,
   input  wire logic linreg0_vout_invalid,
   input  wire logic linreg0_current_limited,
   // top-level monitors
   input  wire logic power_ok_pin_state,
   input  wire logic ext_clk_invalid,
   input  wire logic thermal_warning_state,
   input  wire logic load_meas_done,
   // interrupt, active high
   output logic      irq
);
   rsirq_state_e st_reg, st_next;
   logic [3:0]   cnt_reg, cnt_next;
   logic [7:0]   sh_reg, sh_next;
   logic [7:0]   ptr_reg, ptr_next;
   logic         rw_reg, rw_next;
   logic         oe_reg, oe_next;
   logic         ack_ok_reg, ack_ok_next;
   logic         wr_en_reg, wr_en_next;
   logic         scl_prev_reg, sda_prev_reg;
   logic         irq_reg;
   logic         scl_rise, scl_fall, start_cond, stop_cond;
   logic [7:0]   rd_data;
   logic         irq_req;

   // bus edge and condition detection
   assign scl_rise   = scl_in & ~scl_prev_reg;
   assign scl_fall   = ~scl_in & scl_prev_reg;
   assign start_cond = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
   assign stop_cond  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

   // serial engine next state; data moves on scl fall, sampling on scl rise
   always_comb begin
      st_next     = st_reg;
      cnt_next    = cnt_reg;
      sh_next     = sh_reg;
      ptr_next    = ptr_reg;
      rw_next     = rw_reg;
      oe_next     = oe_reg;
      ack_ok_next = ack_ok_reg;
      wr_en_next  = 1'b0;
      if (start_cond) begin
         // repeated start is accepted in any state
         st_next  = ST_ADDR;
         cnt_next = 4'h0;
         oe_next  = 1'b0;
      end else if (stop_cond) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
      end else begin
         case (st_reg)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (scl_rise) begin
                  sh_next  = {sh_reg[6:0], sda_in};
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall && cnt_reg == BITS_PER_BYTE) begin
                  cnt_next = 4'h0;
                  oe_next  = 1'b1;
                  if (st_reg == ST_ADDR) begin
                     rw_next = sh_reg[0];
                     if (sh_reg[7:1] == DEV_ADDR) begin
                        st_next = ST_ACK_A;
                     end else begin
                        // not our address: stay silent until next start
                        st_next = ST_IDLE;
                        oe_next = 1'b0;
                     end
                  end else if (st_reg == ST_REG) begin
                     st_next  = ST_ACK_R;
                     ptr_next = sh_reg;
                  end else begin
                     // one-cycle write strobe while ptr and data are stable
                     st_next    = ST_ACK_W;
                     wr_en_next = 1'b1;
                  end
               end
            end
            ST_ACK_A: begin
               if (scl_fall) begin
                  if (rw_reg) begin
                     st_next = ST_RDATA;
                     sh_next = rd_data;
                     oe_next = ~rd_data[7];
                  end else begin
                     st_next = ST_REG;
                     oe_next = 1'b0;
                  end
               end
            end
            ST_ACK_R, ST_ACK_W: begin
               if (scl_fall) begin
                  st_next = ST_WDATA;
                  oe_next = 1'b0;
                  if (st_reg == ST_ACK_W) begin
                     ptr_next = ptr_reg + 8'h01;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_reg == BITS_PER_BYTE) begin
                     st_next  = ST_RACK;
                     cnt_next = 4'h0;
                     oe_next  = 1'b0;
                  end else begin
                     oe_next = ~sh_reg[~cnt_reg[2:0]];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  // advance here so the next byte is ready by the fall
                  ack_ok_next = ~sda_in;
                  ptr_next    = ptr_reg + 8'h01;
               end else if (scl_fall) begin
                  if (ack_ok_reg) begin
                     st_next = ST_RDATA;
                     sh_next = rd_data;
                     oe_next = ~rd_data[7];
                  end else begin
                     st_next = ST_IDLE;
                  end
               end
            end
            ST_IDLE: begin
               oe_next = 1'b0;
            end
            default: begin
               st_next = ST_IDLE;
               oe_next = 1'b0;
            end
         endcase
      end
   end

   // serial engine registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_reg       <= ST_IDLE;
         cnt_reg      <= 4'h0;
         sh_reg       <= BYTE_ZERO;
         ptr_reg      <= BYTE_ZERO;
         rw_reg       <= 1'b0;
         oe_reg       <= 1'b0;
         ack_ok_reg   <= 1'b0;
         wr_en_reg    <= 1'b0;
         scl_prev_reg <= 1'b1;  // idle bus is high, avoids a false start
         sda_prev_reg <= 1'b1;
         irq_reg      <= 1'b0;
      end else begin
         st_reg       <= st_next;
         cnt_reg      <= cnt_next;
         sh_reg       <= sh_next;
         ptr_reg      <= ptr_next;
         rw_reg       <= rw_next;
         oe_reg       <= oe_next;
         ack_ok_reg   <= ack_ok_next;
         wr_en_reg    <= wr_en_next;
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
         irq_reg      <= irq_req;
      end
   end

   // open drain: the data level is always low, only the enable moves
   always_ff @(posedge core_clk) begin
      sda_out <= 1'b0;
   end

   assign sda_oe = oe_reg;
   assign irq    = irq_reg;

   // status writes dropped
   // only flags and mask decode a write, status offsets have no storage
   rsirq_regs i_rsirq_regs (
      .core_clk              (core_clk),
      .rst_b                 (rst_b),
      .wr_en                 (wr_en_reg),
      .wr_addr               (ptr_reg),
      .wr_data               (sh_reg),
      .rd_addr               (ptr_reg),
      .rd_data               (rd_data),
      .irq_req               (irq_req),
      .buck_raw              ({conv1_enabled, conv1_vout_invalid, conv1_current_limited,
                               conv0_enabled, conv0_vout_invalid, conv0_current_limited}),
      .ldo_raw               ({linreg1_enabled, linreg1_vout_invalid,
                               linreg1_current_limited, linreg0_enabled,
                               linreg0_vout_invalid, linreg0_current_limited}),
      .power_ok_pin_state    (power_ok_pin_state),
      .ext_clk_invalid       (ext_clk_invalid),
      .thermal_warning_state (thermal_warning_state),
      .load_meas_done        (load_meas_done)
   );
endmodule
`default_nettype wire

// [dv/rsirq_properties.sv]
// Purpose: port-level checks of the rail status and irq mask slice
// Assumes: monitors and bus move as the bench drives them
// Notes:   irq lags its cause by about two cycles
`timescale 1ns/100ps
`default_nettype none
module rsirq_properties (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   // monitors and interrupt
   input wire logic power_ok_pin_state,
   input wire logic ext_clk_invalid,
   input wire logic thermal_warning_state,
   input wire logic load_meas_done,
   input wire logic irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   logic       scl_q, th_q, pok_q, ck_q, used_q;
   logic [3:0] quiet_q, hist_q, ohist_q;
   logic       open_ev, any_ev;
   // events as the slice sees them, open ones are unmasked after reset
   assign open_ev = (thermal_warning_state & ~th_q) | load_meas_done;
   assign any_ev  = open_ev | (power_ok_pin_state ^ pok_q) | (ext_clk_invalid & ~ck_q);
   // history spans the irq lag; quiet counts cycles since scl moved
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         {scl_q, th_q, pok_q, ck_q, used_q} <= 5'h00;
         {quiet_q, hist_q, ohist_q}         <= 12'h000;
      end else begin
         {scl_q, th_q, pok_q, ck_q} <= {scl_in, thermal_warning_state,
                                        power_ok_pin_state, ext_clk_invalid};
         used_q  <= used_q | ~scl_in; // any bus use may have moved the mask
         quiet_q <= (scl_in != scl_q) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
         hist_q  <= {hist_q[2:0], any_ev};
         ohist_q <= {ohist_q[2:0], open_ev};
      end
   end
   sequence s_two_low;
      !irq ##1 !irq;
   endsequence
   sequence s_start;
      scl_in && $past(scl_in) && $fell(sda_in);
   endsequence
   a_irq_quiet_reset: assert property ($rose(rst_b) |-> s_two_low)
      else $error("irq high right after reset");
   a_irq_fall_cause: assert property ($fell(irq) |-> quiet_q < 4'h8)
      else $error("irq dropped with no host write");
   a_irq_rise_cause: assert property ($rose(irq) |-> quiet_q < 4'h8 || hist_q != 4'h0)
      else $error("irq rose with no event or write");
   a_masked_quiet: assert property (!used_q && !$past(irq) && ohist_q == 4'h0 |-> !irq)
      else $error("masked event raised irq");
   a_open_irq: assert property (!used_q && open_ev |-> ##[1:4] irq)
      else $error("unmasked event gave no irq");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda drive moved while scl high");
   a_start_free: assert property (s_start |-> !sda_oe [*4])
      else $error("sda driven at start");
   a_oe_idle_free: assert property (quiet_q == 4'hf |-> !sda_oe)
      else $error("sda held on idle bus");
endmodule
bind rsirq_top rsirq_properties i_rsirq_properties (.core_clk, .rst_b, .scl_in, .sda_in,
   .sda_oe, .power_ok_pin_state, .ext_clk_invalid, .thermal_warning_state, .load_meas_done,
   .irq);
`default_nettype wire

// [dv/rsirq_host.sv]
// Purpose: host model driving the two-wire bus
// Assumes: sda_drv high means released, the line has a pull-up
// Notes:   scl high phases are five cycles, low phases six; sda moves with scl high only for start and stop
`timescale 1ns/100ps
`default_nettype none
module rsirq_host (
   // clock
   input  wire logic core_clk,
   // bus
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_drv
);
   localparam int H = 5;
   // idle bus at time zero
   initial begin
      scl     = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // start or repeated start
   task automatic start();
      sda_drv = 1'b1;
      wt(H);
      scl = 1'b1;
      wt(H);
      sda_drv = 1'b0;
      wt(H);
      scl = 1'b0;
      wt(1);
   endtask
   task automatic stop();
      sda_drv = 1'b0;
      wt(H);
      scl = 1'b1;
      wt(H);
      sda_drv = 1'b1;
      wt(H);
   endtask
   // eight bits and the ack bit, msb first, wire sampled late in scl high
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_drv = tx[i];
         wt(H);
         scl = 1'b1;
         wt(H);
         rx[i] = sda_line;
         scl = 1'b0;
         wt(1);
      end
   endtask
   task automatic wr(input logic [6:0] dev, input logic [7:0] a, d, output logic ok);
      logic [8:0] r0, r1, r2;
      start();
      xfer({dev, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      xfer({d, 1'b1}, r2);
      stop();
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask
   // pointer write, repeated start, one byte read and nacked
   task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                     output logic ok);
      logic [8:0] r0, r1, r2, r3;
      start();
      xfer({dev, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      start();
      xfer({dev, 2'b11}, r2);
      xfer(9'h1ff, r3);
      stop();
      d  = r3[8:1];
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask
   // pointer write, repeated start, two bytes read, the first acked by the host
   task automatic rd2(input logic [6:0] dev, input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
      logic [8:0] r0, r1, r2, r3, r4;
      start();
      xfer({dev, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      start();
      xfer({dev, 2'b11}, r2);
      xfer(9'h1fe, r3);
      xfer(9'h1ff, r4);
      stop();
      d  = {r3[8:1], r4[8:1]};
      ok = !(r0[0] | r1[0] | r2[0]);
   endtask
   // two data bytes to consecutive registers, exercises the write pointer step
   task automatic wr2(input logic [6:0] dev, input logic [7:0] a, d0, d1, output logic ok);
      logic [8:0] r0, r1, r2, r3;
      start();
      xfer({dev, 2'b01}, r0);
      xfer({a, 1'b1}, r1);
      xfer({d0, 1'b1}, r2);
      xfer({d1, 1'b1}, r3);
      stop();
      ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
   endtask
endmodule
`default_nettype wire

// [dv/tb_rsirq_top.sv]
// Purpose: self-checking bench for the rail status and irq mask slice
// Assumes: model keeps mask and flags as integers
// Notes:   monitors move at the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module tb_rsirq_top
   import rsirq_pkg::*;
();
   logic       core_clk, rst_b, scl, sda_drv, sda_out, sda_oe, irq, ok;
   logic       pok, cki, th, meas;
   logic [5:0] bk, lr;
   logic [7:0] rd_v;
   logic [15:0] rd2_v;
   wire logic  sda_w;
   int         n_errors, tests_run, m, f;
   // open drain line, low wins; the driven level comes from the data pin so it is checked too
   assign sda_w = sda_drv & (sda_oe ? sda_out : 1'b1);
   rsirq_host i_rsirq_host (.core_clk(core_clk), .sda_line(sda_w), .scl(scl), .sda_drv(sda_drv));
   rsirq_top i_rsirq_top (
      .core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .conv1_enabled(bk[5]), .conv1_vout_invalid(bk[4]), .conv1_current_limited(bk[3]),
      .conv0_enabled(bk[2]), .conv0_vout_invalid(bk[1]), .conv0_current_limited(bk[0]),
      .linreg1_enabled(lr[5]), .linreg1_vout_invalid(lr[4]), .linreg1_current_limited(lr[3]),
      .linreg0_enabled(lr[2]), .linreg0_vout_invalid(lr[1]), .linreg0_current_limited(lr[0]),
      .power_ok_pin_state(pok), .ext_clk_invalid(cki), .thermal_warning_state(th),
      .load_meas_done(meas), .irq(irq));
   // 200 MHz
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   function automatic logic [7:0] pack(input logic [5:0] r);
      return {r[5], r[4], 1'b0, r[3], r[2], r[1], 1'b0, r[0]};
   endfunction
   // expected register contents from the model
   function automatic logic [7:0] expect_of(input logic [7:0] a);
      case (a)
         OFS_FLAGS:     return f[7:0];
         OFS_TOP_STAT:  return {pok, 2'b00, cki, 1'b0, th, 2'b00};
         OFS_BUCK_STAT: return pack(bk);
         OFS_LDO_RAIL_STATUS:  return pack(lr);
         OFS_MASK:      return m[7:0];
         default:       return 8'h00;
      endcase
   endfunction
   task automatic cmp(input string nm, input logic [7:0] e, s);
      tests_run++;
      if (s !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         n_errors++;
      end
   endtask
   task automatic chk(input logic [7:0] a);
      i_rsirq_host.rd(DEV_ADDR_DFLT, a, rd_v, ok);
      cmp("read ack", 8'h01, {7'h00, ok});
      cmp($sformatf("reg %h", a), expect_of(a), rd_v);
   endtask
   // writes to status places leave the model alone
   task automatic put(input logic [7:0] a, d);
      i_rsirq_host.wr(DEV_ADDR_DFLT, a, d, ok);
      cmp("write ack", 8'h01, {7'h00, ok});
      if (a == OFS_FLAGS) f = f & ~int'(d);
      if (a == OFS_MASK) m = d;
   endtask
   task automatic chk_irq();
      repeat (6) @(negedge core_clk);
      cmp("irq", {7'h00, (f & ~m) != 0}, {7'h00, irq});
   endtask
   // move monitors; pin change, clock and thermal rise, meas pulse latch
   task automatic mon(input logic p, c, t, e);
      @(negedge core_clk);
      if (p != pok) f = f | 'h80;
      if (c && !cki) f = f | 'h10;
      if (t && !th) f = f | 'h04;
      if (e) f = f | 'h01;
      {pok, cki, th, meas} = {p, c, t, e};
      @(negedge core_clk);
      meas = 1'b0;
      chk_irq();
   endtask
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (20) @(negedge core_clk);
      rst_b = 1'b1;
      m = 'h90;
      f = 0;
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // hang guard
   initial begin
      repeat (90000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end
   initial begin
      {pok, cki, th, meas, bk, lr} = '0;
      n_errors  = 0;
      tests_run = 0;
      void'($urandom(32'h5287));
      do_reset();
      mon(1, 0, 0, 0); // pin change held off
      mon(1, 1, 0, 0); // clock fault held off
      mon(1, 1, 1, 0); // thermal open
      chk(OFS_MASK); // reset value
      chk(OFS_FLAGS); // events latched
      chk(OFS_TOP_STAT); // live status
      put(OFS_FLAGS, 8'h04); // clear thermal only
      chk_irq(); // irq drops
      put(OFS_FLAGS, 8'h90); // clear the rest
      mon(1, 1, 1, 1); // measurement open
      put(OFS_MASK, 8'h01);
      chk_irq(); // gated flag quiet
      put(OFS_MASK, 8'h00);
      chk_irq(); // unmasking raises irq
      put(OFS_FLAGS, 8'h01);
      put(OFS_MASK, 8'h04);
      mon(1, 1, 0, 0);
      mon(1, 1, 1, 0); // thermal gated
      mon(0, 0, 1, 0); // pin change open
      chk(OFS_TOP_STAT); // mask leaves status
      for (int i = 0; i < 4; i++) begin
         put(OFS_MASK, 8'($urandom));
         chk(OFS_MASK); // read back
         chk_irq(); // gating
      end
      put(OFS_FLAGS, 8'hff);
      chk(OFS_FLAGS); // all cleared
      for (int i = 0; i < 8; i++) begin
         bk = 6'($urandom);
         lr = 6'($urandom);
         chk(OFS_BUCK_STAT); // buck fields
         chk(OFS_LDO_RAIL_STATUS); // regulator fields
         put(OFS_BUCK_STAT, 8'($urandom));
         put(OFS_LDO_RAIL_STATUS, 8'($urandom));
         chk(OFS_BUCK_STAT); // write ignored
         chk(OFS_LDO_RAIL_STATUS); // write ignored
      end
      chk(8'h40); // unmapped reads zero
      i_rsirq_host.wr(~DEV_ADDR_DFLT, OFS_MASK, 8'h5a, ok);
      cmp("stray ack", 8'h00, {7'h00, ok});
      chk(OFS_MASK);
      // burst write: status byte dropped, pointer steps on to the mask
      i_rsirq_host.wr2(DEV_ADDR_DFLT, OFS_LDO_RAIL_STATUS, 8'hff, 8'h12, ok);
      cmp("burst write ack", 8'h01, {7'h00, ok});
      m = 'h12;
      chk(OFS_MASK); // second byte landed
      chk(OFS_LDO_RAIL_STATUS); // first byte ignored
      // burst read with host ack between bytes
      i_rsirq_host.rd2(DEV_ADDR_DFLT, OFS_BUCK_STAT, rd2_v, ok);
      cmp("burst read ack", 8'h01, {7'h00, ok});
      cmp("burst read first", pack(bk), rd2_v[15:8]);
      cmp("burst read second", pack(lr), rd2_v[7:0]);
      mon(0, 0, 0, 0);
      do_reset();
      chk_irq(); // quiet after reset
      chk(OFS_MASK); // reset again
      chk(OFS_FLAGS); // flags cleared by reset
      wrap_up();
   end
endmodule
`default_nettype wire
